// ===== bench/dbb_jtag_host.sv
`timescale 1ns/100ps
module dbb_jtag_host
  import dbb_pkg::*;
(
  output logic       tck,
  output logic       tdi,
  output logic       shift_dr,
  output logic       update_dr,
  output logic       tlr,
  output logic [2:0] ir,
  input  wire logic  tdo
);
  // link idles with tck standing low
  initial begin
    tck = 1'b0;
    tdi = 1'b0;
    shift_dr = 1'b0;
    update_dr = 1'b0;
    tlr = 1'b0;
    ir = IR_DEBUG;
  end
  // one 94 ns test clock period
  task automatic tick();
    #31.5 tck = 1'b1;
    #62.5 tck = 1'b0;
  endtask
  // data scan, then update, then one idle clock so tdo shows the new lsb
  task automatic scan(input logic [2:0] code, input int n, input logic [9:0] din, output logic [9:0] dout);
    dout = '0;
    ir = code;
    shift_dr = 1'b1;
    for (int i = 0; i < n; i++) begin
      #31.0 tdi = din[i];
      #31.0 dout[i] = tdo;
      #0.5 tck = 1'b1;
      #62.5 tck = 1'b0;
    end
    #31.0 shift_dr = 1'b0;
    update_dr = 1'b1;
    tick();
    #31.0 update_dr = 1'b0;
    tick();
    tdi = ~tdi;
    #62.5;
  endtask
  // pass the tap through test-logic-reset
  task automatic reset_tap();
    tlr = 1'b1;
    #200 tlr = 1'b0;
    #100;
  endtask
endmodule

// ===== bench/test_debug_buffer_and_boot_select.sv
`timescale 1ns/100ps
module test_debug_buffer_and_boot_select
  import dbb_pkg::*;
;
  logic        MCLK, RESETN, PORN, TCK, TDI, TAP_SHIFT_DR, TAP_UPDATE_DR, TAP_TLR, TDO;
  logic        CPU_WE, CPU_RE, ENG_LOAD_ADDR, ENG_LOAD_DATA, BP_PATTERN_MODE, BP_DEST_HIT;
  logic        DEST_WE, DATA_BREAK, I2C_PROGRAMMING_ENABLE_SET, I2C_PROGRAMMING_ENABLE_CLR, PW_MATCH, PW_LOCK, BOOT_VALID;
  logic [2:0]  TAP_IR;
  logic [4:0]  CPU_ADDR;
  logic [1:0]  BOOT_PATH;
  logic [15:0] CPU_WDATA, CPU_RDATA, ENG_VALUE, DEST_DATA, PW_WORD, PW_ADDR, BOOT_START;
  logic [15:0] pw_fill, pw_last, a, b, c, m, d;
  logic [15:0] rd_q[$];
  logic        bk_q[$];
  logic        re_d, we_d;
  logic [9:0]  dout;
  int          errors, check_count;

  dbb_debug_buffer dut (
    .MCLK, .RESETN, .PORN, .TCK, .TDI, .TAP_SHIFT_DR, .TAP_UPDATE_DR, .TAP_TLR, .TAP_IR, .TDO,
    .CPU_ADDR, .CPU_WE, .CPU_RE, .CPU_WDATA, .CPU_RDATA, .ENG_LOAD_ADDR, .ENG_LOAD_DATA, .ENG_VALUE,
    .BP_PATTERN_MODE, .BP_DEST_HIT, .DEST_WE, .DEST_DATA, .DATA_BREAK, .I2C_PROGRAMMING_ENABLE_SET, .I2C_PROGRAMMING_ENABLE_CLR,
    .PW_WORD, .PW_MATCH, .PW_ADDR, .PW_LOCK, .BOOT_VALID, .BOOT_PATH, .BOOT_START
  );
  dbb_jtag_host host (
    .tck(TCK), .tdi(TDI), .shift_dr(TAP_SHIFT_DR), .update_dr(TAP_UPDATE_DR),
    .tlr(TAP_TLR), .ir(TAP_IR), .tdo(TDO)
  );

  // password memory, last word kept apart
  assign PW_WORD = (PW_ADDR == PW_LAST) ? pw_last : pw_fill;

  // 100 mhz system clock
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // registered answers compared against the oldest note
  always @(posedge MCLK) begin
    if (re_d === 1'b1) chk(CPU_RDATA, rd_q.pop_front());
    if (we_d === 1'b1) chk(DATA_BREAK, bk_q.pop_front());
    re_d <= CPU_RE;
    we_d <= DEST_WE;
  end

  task automatic cyc();
    @(posedge MCLK);
    #1;
  endtask
  // cpu strobes stay up between back-to-back accesses
  task automatic rd(input logic [4:0] idx, input logic [15:0] exp);
    CPU_ADDR = idx;
    CPU_WE = 1'b0;
    CPU_RE = 1'b1;
    rd_q.push_back(exp);
    cyc();
  endtask
  task automatic wr(input logic [4:0] idx, input logic [15:0] v);
    CPU_ADDR = idx;
    CPU_WDATA = v;
    CPU_RE = 1'b0;
    CPU_WE = 1'b1;
    cyc();
  endtask
  task automatic idle(input int n);
    CPU_RE = 1'b0;
    CPU_WE = 1'b0;
    repeat (n) cyc();
  endtask
  task automatic eng(input logic sel, input logic [15:0] v);
    ENG_VALUE = v;
    ENG_LOAD_ADDR = sel;
    ENG_LOAD_DATA = !sel;
    cyc();
  endtask
  task automatic rst(input int n);
    RESETN = 1'b0;
    repeat (n) cyc();
    chk(PW_ADDR, PW_BASE);
    chk(BOOT_VALID, 1'b0);
    RESETN = 1'b1;
  endtask
  // bounded wait for the boot decision
  task automatic boot(input logic [1:0] path, input logic lock);
    int k;
    k = 0;
    while (BOOT_VALID !== 1'b1 && k < 40) begin
      cyc();
      k++;
    end
    if (k == 40) begin
      errors++;
      finish_test();
    end
    chk(BOOT_PATH, path);
    chk(PW_LOCK, lock);
    chk(BOOT_START, USER_START);
    chk(PW_ADDR, PW_LAST);
  endtask

  // main sequence
  initial begin
    {RESETN, PORN, CPU_WE, CPU_RE, ENG_LOAD_ADDR, ENG_LOAD_DATA} = '0;
    {BP_PATTERN_MODE, BP_DEST_HIT, DEST_WE, I2C_PROGRAMMING_ENABLE_SET, I2C_PROGRAMMING_ENABLE_CLR, PW_MATCH} = '0;
    {CPU_ADDR, CPU_WDATA, ENG_VALUE, DEST_DATA} = '0;
    pw_fill = 16'h5A5A;
    pw_last = 16'h5A5A;
    errors = 0;
    check_count = 0;
    void'($urandom(32'h03D1DBFC));
    repeat (20) cyc();
    PORN = 1'b1;
    RESETN = 1'b1;
    boot(BOOT_USER, 1'b1);
    rd(IDX_DBUF, DBUF_RST);
    rd(IDX_AMASK, REG16_RST);
    rd(IDX_DMATCH, REG16_RST);
    rd(IDX_FLAGS, 16'h0000);
    rd(5'h05, 16'h0000);
    a = 16'($urandom);
    wr(IDX_DBUF, a);
    wr(IDX_AMASK, 16'hFFFF);
    wr(IDX_DMATCH, 16'hFFFF);
    wr(IDX_FLAGS, 16'hFFF3);
    rd(IDX_DBUF, {8'h00, a[7:0]});
    rd(IDX_AMASK, REG16_RST);
    rd(IDX_DMATCH, REG16_RST);
    rd(IDX_FLAGS, 16'h0003);
    idle(2);
    $display("register test done");
    // pattern breakpoint with masks, modes and hits varied
    for (int k = 0; k < 12; k++) begin
      m = (k < 2) ? 16'h0000 : 16'($urandom);
      c = 16'($urandom);
      d = k[0] ? ((c & m) | (16'($urandom) & ~m)) : 16'($urandom);
      eng(1'b1, m);
      eng(1'b0, c);
      {ENG_LOAD_ADDR, ENG_LOAD_DATA} = 2'b00;
      BP_PATTERN_MODE = (k % 4 != 3);
      BP_DEST_HIT = (k % 5 != 4);
      DEST_DATA = d;
      DEST_WE = 1'b1;
      bk_q.push_back(BP_PATTERN_MODE & BP_DEST_HIT & (((d ^ c) & m) == 16'h0000));
      cyc();
      DEST_WE = 1'b0;
    end
    rd(IDX_AMASK, m);
    rd(IDX_DMATCH, c);
    idle(2);
    $display("breakpoint test done");
    // debug frames exchange with the byte buffer
    a = 16'($urandom);
    b = 16'($urandom);
    c = 16'($urandom);
    wr(IDX_DBUF, a);
    wr(IDX_FLAGS, 16'h0000);
    idle(1);
    host.scan(IR_DEBUG, DSR_W, {b[7:0], 2'b00}, dout);
    cyc();
    rd(IDX_DBUF, {8'h00, b[7:0]});
    rd(IDX_FLAGS, 16'h0001);
    idle(1);
    host.scan(IR_DEBUG, DSR_W, {c[7:0], 2'b00}, dout);
    chk(dout, {a[7:0], ST_BUSY});
    host.scan(IR_DEBUG, DSR_W, 10'h000, dout);
    chk(dout, {b[7:0], ST_VALID});
    cyc();
    wr(IDX_FLAGS, 16'h0003);
    idle(1);
    host.scan(IR_DEBUG, DSR_W, 10'h000, dout);
    chk(dout, {c[7:0], ST_VALID});
    cyc();
    rd(IDX_FLAGS, 16'h0002);
    wr(IDX_FLAGS, 16'h0000);
    idle(1);
    $display("debug link test done");
    // every programming buffer code
    for (int i = 0; i < 8; i++) begin
      host.scan(IR_SYSPROG, PB_W, 10'(i), dout);
      cyc();
      rd(IDX_FLAGS, 16'({i[2:1], i[0], 1'b0}));
      idle(1);
    end
    host.scan(3'h7, PB_W, 10'h000, dout);
    cyc();
    rd(IDX_FLAGS, 16'h000E);
    wr(IDX_DBUF, a);
    idle(1);
    rst(4);
    boot(BOOT_LOADER, 1'b1);
    rd(IDX_FLAGS, 16'h000E);
    rd(IDX_DBUF, DBUF_RST);
    idle(1);
    host.reset_tap();
    cyc();
    rd(IDX_FLAGS, 16'h0000);
    idle(1);
    $display("programming buffer test done");
    // blank and valid passwords, i2c enable kept over reset
    pw_fill = 16'hFFFF;
    pw_last = 16'hFFFF;
    rst(4);
    boot(BOOT_I2C, 1'b0);
    rd(IDX_FLAGS, 16'h0004);
    idle(1);
    pw_fill = 16'h0000;
    pw_last = (16'($urandom) & 16'h7FFF) | 16'h0001;
    rst(4);
    boot(BOOT_I2C, 1'b1);
    I2C_PROGRAMMING_ENABLE_CLR = 1'b1;
    cyc();
    I2C_PROGRAMMING_ENABLE_CLR = 1'b0;
    rst(4);
    boot(BOOT_USER, 1'b1);
    PW_MATCH = 1'b1;
    cyc();
    PW_MATCH = 1'b0;
    cyc();
    chk(PW_LOCK, 1'b0);
    I2C_PROGRAMMING_ENABLE_SET = 1'b1;
    cyc();
    I2C_PROGRAMMING_ENABLE_SET = 1'b0;
    rst(4);
    boot(BOOT_I2C, 1'b1);
    I2C_PROGRAMMING_ENABLE_CLR = 1'b1;
    cyc();
    I2C_PROGRAMMING_ENABLE_CLR = 1'b0;
    pw_last = 16'h0000;
    rst(4);
    boot(BOOT_I2C, 1'b0);
    idle(2);
    $display("boot path test done");
    finish_test();
  end
endmodule

// ===== include/dbb_boot_if.sv
`timescale 1ns/100ps
interface dbb_boot_if
  import dbb_pkg::*;
();
  logic      programming_enable;
  logic      i2c_programming_enable;
  logic      blank_set;
  logic      decide;
  dbb_path_e path;
  modport core (output programming_enable, output i2c_programming_enable, input blank_set, input decide, input path);
  modport boot (input programming_enable, input i2c_programming_enable, output blank_set, output decide, output path);
endinterface

// ===== include/dbb_pkg.sv
package dbb_pkg;
  // peripheral register indices
  localparam logic [4:0]  IDX_FLAGS  = 5'h1B;
  localparam logic [4:0]  IDX_DBUF   = 5'h1C;
  localparam logic [4:0]  IDX_AMASK  = 5'h1D;
  localparam logic [4:0]  IDX_DMATCH = 5'h1E;
  // debug flag register fields
  localparam int          FLG_TXC    = 0;
  localparam int          FLG_BSEL   = 1;
  localparam int          FLG_PSS_LO = 2;
  localparam int          FLG_PSS_HI = 3;
  // reset values
  localparam logic [7:0]  DBUF_RST   = 8'h00;
  localparam logic [15:0] REG16_RST  = 16'h0000;
  localparam logic [2:0]  PB_RST     = 3'h0;
  // tap instructions and shift paths
  localparam logic [2:0]  IR_DEBUG   = 3'h2;
  localparam logic [2:0]  IR_SYSPROG = 3'h4;
  localparam int          DSR_W      = 10;
  localparam int          PB_W       = 3;
  localparam logic [1:0]  ST_BUSY    = 2'h2;
  localparam logic [1:0]  ST_VALID   = 2'h3;
  // programming source select encodings
  localparam logic [1:0]  PSS_JTAG   = 2'h0;
  localparam logic [1:0]  PSS_I2C    = 2'h1;
  // password area and user entry
  localparam logic [15:0] PW_BASE    = 16'h0020;
  localparam logic [15:0] PW_LAST    = 16'h003E;
  localparam logic [15:0] PW_STEP    = 16'h0002;
  localparam logic [15:0] WORD_ZERO  = 16'h0000;
  localparam logic [15:0] WORD_ONES  = 16'hFFFF;
  localparam logic [15:0] USER_START = 16'h0000;
  // pin synchroniser and timing
  localparam int          SYNC_W     = 8;
  localparam int          CLK_NS     = 10;
  localparam int          TCK_RATIO  = 8;
  localparam int          TCK_MIN_NS = CLK_NS * TCK_RATIO;
  typedef enum logic [1:0] {
    BOOT_USER   = 2'b00,
    BOOT_LOADER = 2'b01,
    BOOT_I2C    = 2'b10
  } dbb_path_e;
  typedef enum logic [1:0] {
    BS_SCAN   = 2'b00,
    BS_DECIDE = 2'b01,
    BS_DONE   = 2'b10
  } dbb_bstate_e;
endpackage

// ===== logic/dbb_boot_path.sv
`timescale 1ns/100ps
module dbb_boot_path
  import dbb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] pw_word,
  input  wire logic        pw_match,
  output logic      [15:0] pw_addr,
  output logic             pw_lock,
  output logic             boot_valid,
  output logic      [1:0]  boot_path,
  output logic      [15:0] boot_start,
  dbb_boot_if.boot         bif
);
  dbb_bstate_e state_r;
  logic [15:0] addr_r;
  logic        all0_r;
  logic        all1_r;
  logic        lock_r;
  dbb_path_e   path_r;
  logic        blank;

  assign blank = all0_r | all1_r;

  // password scan after every reset release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= BS_SCAN;
      addr_r  <= PW_BASE;
      all0_r  <= 1'b1;
      all1_r  <= 1'b1;
    end else begin
      case (state_r)
        BS_SCAN: begin
          all0_r <= all0_r & (pw_word == WORD_ZERO);
          all1_r <= all1_r & (pw_word == WORD_ONES);
          if (addr_r == PW_LAST) begin
            state_r <= BS_DECIDE;
          end else begin
            addr_r <= addr_r + PW_STEP;
          end
        end
        BS_DECIDE: state_r <= BS_DONE;
        BS_DONE:   state_r <= BS_DONE;
        default:   state_r <= BS_SCAN;
      endcase
    end
  end

  // boot path choice, loader request first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      path_r <= BOOT_USER;
    end else if (state_r == BS_DECIDE) begin
      if (bif.programming_enable) begin
        path_r <= BOOT_LOADER;
      end else if (bif.i2c_programming_enable || blank) begin
        path_r <= BOOT_I2C;
      end else begin
        path_r <= BOOT_USER;
      end
    end
  end

  // lock set by a valid password, cleared by a match
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_r <= 1'b0;
    end else if (state_r == BS_DECIDE && !blank && !bif.programming_enable && !bif.i2c_programming_enable) begin
      lock_r <= 1'b1;
    end else if (state_r == BS_DECIDE && !blank) begin
      lock_r <= 1'b1;
    end else if (pw_match) begin
      lock_r <= 1'b0;
    end
  end

  assign pw_addr       = addr_r;
  assign pw_lock       = lock_r;
  assign boot_valid    = (state_r == BS_DONE);
  assign boot_path     = path_r;
  assign boot_start    = USER_START;
  assign bif.decide    = (state_r == BS_DECIDE);
  assign bif.path      = (bif.programming_enable) ? BOOT_LOADER : ((bif.i2c_programming_enable || blank) ? BOOT_I2C : BOOT_USER);
  assign bif.blank_set = (state_r == BS_DECIDE) && blank && !bif.programming_enable;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_lock_clr;
    pw_match && (state_r != BS_DECIDE) |=> !pw_lock;
  endproperty
  a_lock_clr: assert property (p_lock_clr) else $error("lock not cleared by match");

  property p_blank_i2c;
    (state_r == BS_DECIDE) && blank && !bif.programming_enable |=> (boot_path == BOOT_I2C) && !pw_lock;
  endproperty
  a_blank_i2c: assert property (p_blank_i2c) else $error("blank password not forced to i2c");

  property p_scan_len;
    $fell(state_r == BS_SCAN) |-> $past(pw_addr) == PW_LAST;
  endproperty
  a_scan_len: assert property (p_scan_len) else $error("scan ended at wrong word");
endmodule

// ===== logic/dbb_debug_buffer.sv
`timescale 1ns/100ps
module dbb_debug_buffer
  import dbb_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic        PORN,
  input  wire logic        TCK,
  input  wire logic        TDI,
  input  wire logic        TAP_SHIFT_DR,
  input  wire logic        TAP_UPDATE_DR,
  input  wire logic        TAP_TLR,
  input  wire logic [2:0]  TAP_IR,
  output logic             TDO,
  input  wire logic [4:0]  CPU_ADDR,
  input  wire logic        CPU_WE,
  input  wire logic        CPU_RE,
  input  wire logic [15:0] CPU_WDATA,
  output logic      [15:0] CPU_RDATA,
  input  wire logic        ENG_LOAD_ADDR,
  input  wire logic        ENG_LOAD_DATA,
  input  wire logic [15:0] ENG_VALUE,
  input  wire logic        BP_PATTERN_MODE,
  input  wire logic        BP_DEST_HIT,
  input  wire logic        DEST_WE,
  input  wire logic [15:0] DEST_DATA,
  output logic             DATA_BREAK,
  input  wire logic        I2C_PROGRAMMING_ENABLE_SET,
  input  wire logic        I2C_PROGRAMMING_ENABLE_CLR,
  input  wire logic [15:0] PW_WORD,
  input  wire logic        PW_MATCH,
  output logic      [15:0] PW_ADDR,
  output logic             PW_LOCK,
  output logic             BOOT_VALID,
  output logic      [1:0]  BOOT_PATH,
  output logic      [15:0] BOOT_START
);
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_s1_r;
  logic [SYNC_W-1:0] pin_s2_r;
  logic              tck_d_r;
  logic              tck_s;
  logic              tdi_s;
  logic              shdr_s;
  logic              upd_s;
  logic              tlr_s;
  logic [2:0]        ir_s;
  logic              tck_rise;
  logic              tck_fall;
  logic [DSR_W-1:0]  dsr_r;
  logic [PB_W-1:0]   psr_r;
  logic              tdo_r;
  logic [7:0]        dbuf_r;
  logic [PB_W-1:0]   pb_r;
  logic              cpu_spe_r;
  logic              txc_r;
  logic              txc_nxt;
  logic              i2c_programming_enable_r;
  logic [15:0]       amask_r;
  logic [15:0]       dmatch_r;
  logic              brk_r;
  logic [15:0]       rdata_r;
  logic              loader;
  logic              xfer_done;
  logic              pb_load;
  logic              flags_wr;
  logic              dbuf_wr;

  dbb_boot_if bif ();

  // register index decode, shared by reads and writes
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] idx);
    hit = (addr == idx);
  endfunction

  // pattern compare, only masked-in bits count
  function automatic logic pattern_hit(input logic [15:0] data, input logic [15:0] match,
                                       input logic [15:0] mask);
    pattern_hit = (((data ^ match) & mask) == REG16_RST);
  endfunction

  // two-flop synchronisers on every tap pin
  assign pin_raw = {TCK, TDI, TAP_SHIFT_DR, TAP_UPDATE_DR, TAP_TLR, TAP_IR};
  generate
    for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
      always_ff @(posedge MCLK) begin
        if (!RESETN) begin
          pin_s1_r[i] <= 1'b0;
          pin_s2_r[i] <= 1'b0;
        end else begin
          pin_s1_r[i] <= pin_raw[i];
          pin_s2_r[i] <= pin_s1_r[i];
        end
      end
    end
  endgenerate

  assign {tck_s, tdi_s, shdr_s, upd_s, tlr_s, ir_s} = pin_s2_r;

  // test clock edge finder, needs tck under an eighth of mclk
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      tck_d_r <= 1'b0;
    end else begin
      tck_d_r <= tck_s;
    end
  end

  assign tck_rise  = tck_s & ~tck_d_r;
  assign tck_fall  = ~tck_s & tck_d_r;
  assign loader    = cpu_spe_r | pb_r[0];
  assign xfer_done = tck_fall & upd_s & (ir_s == IR_DEBUG);
  assign pb_load   = tck_fall & upd_s & (ir_s == IR_SYSPROG);
  assign flags_wr  = CPU_WE & hit(CPU_ADDR, IDX_FLAGS);
  assign dbuf_wr   = CPU_WE & hit(CPU_ADDR, IDX_DBUF);

  // debug and programming shift paths on rising test clock
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      dsr_r <= '0;
      psr_r <= '0;
    end else if (xfer_done) begin
      dsr_r <= {dbuf_r, (txc_r ? ST_VALID : ST_BUSY)};
    end else if (tck_rise && shdr_s) begin
      if (ir_s == IR_SYSPROG) begin
        psr_r <= {tdi_s, psr_r[PB_W-1:1]};
      end else if (ir_s == IR_DEBUG) begin
        dsr_r <= {tdi_s, dsr_r[DSR_W-1:1]};
      end
    end
  end

  // serial out changes on falling test clock
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      tdo_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_r <= (ir_s == IR_SYSPROG) ? psr_r[0] : dsr_r[0];
    end
  end

  // debug byte buffer, exchange beats a cpu write
  always_ff @(posedge MCLK) begin
    if (!RESETN || !PORN) begin
      dbuf_r <= DBUF_RST;
    end else if (xfer_done) begin
      dbuf_r <= dsr_r[DSR_W-1:2];
    end else if (dbuf_wr) begin
      dbuf_r <= CPU_WDATA[7:0];
    end
  end

  // transfer flag, a set always wins
  always_comb begin
    txc_nxt = txc_r;
    if (xfer_done) begin
      txc_nxt = ~loader;
    end
    if (flags_wr) begin
      txc_nxt = CPU_WDATA[FLG_TXC] | (xfer_done & ~loader);
    end
  end

  // flag bits kept over ordinary reset
  always_ff @(posedge MCLK) begin
    if (!PORN) begin
      txc_r     <= 1'b0;
      cpu_spe_r <= 1'b0;
    end else begin
      txc_r <= txc_nxt;
      if (flags_wr) begin
        cpu_spe_r <= CPU_WDATA[FLG_BSEL];
      end
    end
  end

  // programming buffer, tap reset clears it
  always_ff @(posedge MCLK) begin
    if (!PORN || tlr_s) begin
      pb_r <= PB_RST;
    end else if (pb_load) begin
      pb_r <= psr_r;
    end else if (bif.decide && bif.path == BOOT_I2C) begin
      pb_r[2:1] <= PSS_I2C;
    end else if (flags_wr) begin
      pb_r[2:1] <= CPU_WDATA[FLG_PSS_HI:FLG_PSS_LO];
    end
  end

  // i2c programming enable, set wins
  always_ff @(posedge MCLK) begin
    if (!PORN) begin
      i2c_programming_enable_r <= 1'b0;
    end else if (I2C_PROGRAMMING_ENABLE_SET || bif.blank_set) begin
      i2c_programming_enable_r <= 1'b1;
    end else if (I2C_PROGRAMMING_ENABLE_CLR) begin
      i2c_programming_enable_r <= 1'b0;
    end
  end

  // engine loaded mask and match words
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      amask_r  <= REG16_RST;
      dmatch_r <= REG16_RST;
    end else begin
      if (ENG_LOAD_ADDR) begin
        amask_r <= ENG_VALUE;
      end
      if (ENG_LOAD_DATA) begin
        dmatch_r <= ENG_VALUE;
      end
    end
  end

  // data pattern break on a destination write
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      brk_r <= 1'b0;
    end else begin
      brk_r <= DEST_WE & BP_DEST_HIT & BP_PATTERN_MODE &
               pattern_hit(DEST_DATA, dmatch_r, amask_r);
    end
  end

  // cpu read port, one cycle late
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      rdata_r <= REG16_RST;
    end else if (CPU_RE) begin
      if (hit(CPU_ADDR, IDX_FLAGS)) begin
        rdata_r <= {12'h000, pb_r[2:1], cpu_spe_r | pb_r[0], txc_r};
      end else if (hit(CPU_ADDR, IDX_DBUF)) begin
        rdata_r <= {8'h00, dbuf_r};
      end else if (hit(CPU_ADDR, IDX_AMASK)) begin
        rdata_r <= amask_r;
      end else if (hit(CPU_ADDR, IDX_DMATCH)) begin
        rdata_r <= dmatch_r;
      end else begin
        rdata_r <= REG16_RST;
      end
    end
  end

  assign bif.programming_enable     = loader;
  assign bif.i2c_programming_enable = i2c_programming_enable_r;

  dbb_boot_path u_boot (
    .clk        (MCLK),
    .rst_n      (RESETN),
    .pw_word    (PW_WORD),
    .pw_match   (PW_MATCH),
    .pw_addr    (PW_ADDR),
    .pw_lock    (PW_LOCK),
    .boot_valid (BOOT_VALID),
    .boot_path  (BOOT_PATH),
    .boot_start (BOOT_START),
    .bif        (bif.boot)
  );

  assign TDO        = tdo_r;
  assign CPU_RDATA  = rdata_r;
  assign DATA_BREAK = brk_r;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN || !PORN);

  property p_bsel_or;
    CPU_RE && hit(CPU_ADDR, IDX_FLAGS) |=> CPU_RDATA[FLG_BSEL] == $past(cpu_spe_r | pb_r[0]);
  endproperty
  a_bsel_or: assert property (p_bsel_or) else $error("boot select read not the or");

  property p_txc_hw;
    xfer_done && !loader |=> txc_r;
  endproperty
  a_txc_hw: assert property (p_txc_hw) else $error("transfer flag not set");

  property p_txc_cpu;
    flags_wr && CPU_WDATA[FLG_TXC] |=> txc_r;
  endproperty
  a_txc_cpu: assert property (p_txc_cpu) else $error("cpu set of transfer flag lost");

  property p_exchange;
    xfer_done |=> (dbuf_r == $past(dsr_r[DSR_W-1:2])) && (dsr_r[DSR_W-1:2] == $past(dbuf_r));
  endproperty
  a_exchange: assert property (p_exchange) else $error("buffer exchange wrong");

  property p_mask_miss;
    DEST_WE && BP_DEST_HIT && BP_PATTERN_MODE && (((DEST_DATA ^ dmatch_r) & amask_r) != 16'h0000)
      |=> !DATA_BREAK;
  endproperty
  a_mask_miss: assert property (p_mask_miss) else $error("break on masked mismatch");

  property p_all_clear;
    DEST_WE && BP_DEST_HIT && BP_PATTERN_MODE && (amask_r == 16'h0000) |=> DATA_BREAK;
  endproperty
  a_all_clear: assert property (p_all_clear) else $error("no break with empty mask");

  property p_pb_tlr;
    tlr_s |=> (pb_r == PB_RST) ##1 (pb_r == PB_RST || !$past(tlr_s));
  endproperty
  a_pb_tlr: assert property (p_pb_tlr) else $error("buffer not cleared by logic reset");

  property p_sync_lat;
    tck_rise |-> $past(TCK, 2) && !$past(TCK, 3);
  endproperty
  a_sync_lat: assert property (p_sync_lat) else $error("test clock edge not two flops late");

  property p_i2c_pss;
    bif.decide && (bif.path == BOOT_I2C) && !tlr_s && !pb_load |=> pb_r[2:1] == PSS_I2C;
  endproperty
  a_i2c_pss: assert property (p_i2c_pss) else $error("i2c path left source select");
endmodule
